// file: include/spi_lock_pkg.sv
package spi_lock_pkg;

	// ---------------------------------------------------------------
	// Instruction codes
	// ---------------------------------------------------------------
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_READ_LOCK = 8'h3D;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET_DEVICE = 8'h99;

	// ---------------------------------------------------------------
	// Frame and lock array layout
	// ---------------------------------------------------------------
	localparam int OPCODE_BITS = 8;
	localparam int ADDR_BITS = 24;
	localparam int QUERY_BITS = 32;
	localparam int READ_BITS = 8;
	localparam int LOCK_COUNT = 64;
	localparam int LOCK_IDX_W = 6;
	localparam int LOCK_IDX_LSB = 16;
	localparam int SECTOR_IDX_W = 4;
	localparam int SECTOR_IDX_LSB = 12;
	localparam logic [LOCK_COUNT-1:0] LOCKS_AT_RESET = '1;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_TIME_NS = 30000;
	localparam int RESET_CYCLES =
		(RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SCK_HALF_CYCLES = 8;
	localparam int GAP_CYCLES = 2 * SCK_HALF_CYCLES;
	localparam int CNT_W = 10;

	// ---------------------------------------------------------------
	// Host register map
	// ---------------------------------------------------------------
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int CMD_ADDR_BIT = 8;
	localparam int CMD_READ_BIT = 9;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_DATA_LSB = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;

endpackage

// file: include/spi_lock_if.sv
`timescale 1ns/10ps
interface spi_lock_if;
	logic cs_n;
	logic sck;
	logic mosi;
	logic miso;
	logic miso_oe;

	modport device (input cs_n, input sck, input mosi,
		output miso, output miso_oe);
	modport host (output cs_n, output sck, output mosi,
		input miso, input miso_oe);
endinterface

// file: src/lock_reset_device.sv
`timescale 1ns/10ps
module lock_reset_device (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Serial link
	spi_lock_if.device link,
	// Protection configuration
	input wire logic per_block_protect_select,
	input wire logic protect_complement,
	input wire logic sector_granularity,
	input wire logic top_bottom_select,
	input wire logic [2:0] protect_range_bits,
	// Core state inputs
	input wire logic suspend_set,
	input wire logic wrap_load,
	input wire logic [2:0] wrap_value,
	// Erase and program check
	input wire logic check_valid,
	input wire logic [spi_lock_pkg::ADDR_BITS-1:0] check_addr,
	output logic check_done,
	output logic check_refused,
	// Volatile state
	output logic write_enable_latch_bit,
	output logic suspend_flag,
	output logic [2:0] wrap_setting_bits,
	output logic core_abort,
	output logic reset_busy
);
	import spi_lock_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic sck_prev;
	logic cs_prev;
	logic cs_s;
	logic sck_s;
	logic mosi_s;
	logic sck_rise;
	logic sck_fall;
	logic frame_start;
	logic frame_end;

	// Two flops per pin; only the second one is looked at
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pin_meta <= 3'h4;
			pin_sync <= 3'h4;
		end else begin
			pin_meta <= {link.cs_n, link.sck, link.mosi};
			pin_sync <= pin_meta;
		end
	end

	assign cs_s = pin_sync[2];
	assign sck_s = pin_sync[1];
	assign mosi_s = pin_sync[0];

	// Previous levels for edge finding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sck_prev <= 1'b0;
			cs_prev <= 1'b1;
		end else begin
			sck_prev <= sck_s;
			cs_prev <= cs_s;
		end
	end

	// Clock edges count only inside a frame
	assign sck_rise = sck_s & ~sck_prev & ~cs_s;
	assign sck_fall = ~sck_s & sck_prev & ~cs_s;
	assign frame_start = ~cs_s & cs_prev;
	assign frame_end = cs_s & ~cs_prev;

	// ---------------------------------------------------------------
	// Instruction shifter
	// ---------------------------------------------------------------
	logic [5:0] bit_cnt;
	logic [QUERY_BITS-1:0] shreg;
	logic [QUERY_BITS-1:0] next_shreg;
	logic [7:0] opcode;
	logic [LOCK_COUNT-1:0] locks;
	logic [CNT_W-1:0] busy_cnt;
	logic reset_armed;
	logic exec;
	logic instr_end;
	logic do_reset;

	assign next_shreg = {shreg[QUERY_BITS-2:0], mosi_s};

	// Bits are taken on rising link edges, count saturates
	always_ff @(posedge aclk) begin
		if (!aresetn || frame_start) begin
			bit_cnt <= 6'h00;
			shreg <= '0;
		end else if (sck_rise) begin
			shreg <= next_shreg;
			if (bit_cnt != 6'h3F)
				bit_cnt <= bit_cnt + 6'h01;
		end
	end

	// Opcode is kept once its eighth bit arrives
	always_ff @(posedge aclk) begin
		if (!aresetn)
			opcode <= 8'h00;
		else if (sck_rise && bit_cnt == 6'(OPCODE_BITS - 1))
			opcode <= next_shreg[7:0];
	end

	// A frame counts as an instruction once a full opcode was seen;
	// while the reset interval runs every frame is dropped
	assign instr_end = frame_end && !reset_busy &&
		bit_cnt >= 6'(OPCODE_BITS);
	assign exec = instr_end && bit_cnt == 6'(OPCODE_BITS);
	assign do_reset = exec && opcode == OP_RESET_DEVICE &&
		reset_armed;

	// ---------------------------------------------------------------
	// Reset sequencing
	// ---------------------------------------------------------------
	// Any instruction other than 66h leaves the armed state
	always_ff @(posedge aclk) begin
		if (!aresetn || core_abort)
			reset_armed <= 1'b0;
		else if (instr_end)
			reset_armed <= exec && opcode == OP_RESET_ENABLE;
	end

	// One-cycle abort towards the array core
	always_ff @(posedge aclk) begin
		if (!aresetn)
			core_abort <= 1'b0;
		else
			core_abort <= do_reset;
	end

	// Busy window after a soft reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_cnt <= '0;
			reset_busy <= 1'b0;
		end else if (do_reset) begin
			busy_cnt <= CNT_W'(RESET_CYCLES);
			reset_busy <= 1'b1;
		end else if (busy_cnt != '0) begin
			busy_cnt <= busy_cnt - 1'b1;
			reset_busy <= busy_cnt != CNT_W'(1);
		end
	end

	// ---------------------------------------------------------------
	// Volatile state
	// ---------------------------------------------------------------
	// Write enable latch; a global command spends it
	always_ff @(posedge aclk) begin
		if (!aresetn || core_abort)
			write_enable_latch_bit <= 1'b0;
		else if (exec) begin
			case (opcode)
				OP_WRITE_ENABLE: write_enable_latch_bit <= 1'b1;
				OP_WRITE_DISABLE: write_enable_latch_bit <= 1'b0;
				OP_GLOBAL_LOCK,
				OP_GLOBAL_UNLOCK: write_enable_latch_bit <= 1'b0;
				default: write_enable_latch_bit <= write_enable_latch_bit;
			endcase
		end
	end

	// Suspend and wrap settings are lost on soft reset
	always_ff @(posedge aclk) begin
		if (!aresetn || core_abort) begin
			suspend_flag <= 1'b0;
			wrap_setting_bits <= 3'h0;
		end else begin
			if (suspend_set)
				suspend_flag <= 1'b1;
			if (wrap_load)
				wrap_setting_bits <= wrap_value;
		end
	end

	// Lock array; global commands obey the latch only
	always_ff @(posedge aclk) begin
		if (!aresetn || core_abort)
			locks <= LOCKS_AT_RESET;
		else if (exec && write_enable_latch_bit) begin
			if (opcode == OP_GLOBAL_LOCK)
				locks <= '1;
			else if (opcode == OP_GLOBAL_UNLOCK)
				locks <= '0;
		end
	end

	// ---------------------------------------------------------------
	// Lock query answer
	// ---------------------------------------------------------------
	logic query_on;
	logic [7:0] out_byte;

	// Byte is loaded at the last address bit and shifted out on
	// falling edges; the pin stays undriven outside that phase
	always_ff @(posedge aclk) begin
		if (!aresetn || frame_end || frame_start) begin
			query_on <= 1'b0;
			out_byte <= 8'h00;
			link.miso <= 1'b0;
			link.miso_oe <= 1'b0;
		end else if (sck_rise && !reset_busy &&
			bit_cnt == 6'(QUERY_BITS - 1) && opcode == OP_READ_LOCK) begin
			query_on <= 1'b1;
			out_byte <= {7'h00,
				locks[next_shreg[LOCK_IDX_LSB +: LOCK_IDX_W]]};
		end else if (sck_fall && query_on) begin
			link.miso <= out_byte[7];
			link.miso_oe <= 1'b1;
			out_byte <= {out_byte[6:0], 1'b0};
		end
	end

	// ---------------------------------------------------------------
	// Erase and program guard
	// ---------------------------------------------------------------
	// Range protection from the status bits; top_bottom_select high
	// protects from the bottom of the array up
	function automatic logic range_hit(
		input logic [ADDR_BITS-1:0] addr);
		logic [LOCK_IDX_W-1:0] blk;
		logic [SECTOR_IDX_W-1:0] sec;
		logic [6:0] size;
		logic hit;
		blk = addr[LOCK_IDX_LSB +: LOCK_IDX_W];
		sec = addr[SECTOR_IDX_LSB +: SECTOR_IDX_W];
		size = 7'h01 << (protect_range_bits - 3'h1);
		hit = 1'b0;
		if (protect_range_bits == 3'h0)
			hit = 1'b0;
		else if (!sector_granularity)
			hit = top_bottom_select ? ({1'b0, blk} < size) :
				({1'b0, blk} >= 7'(LOCK_COUNT) - size);
		else if (top_bottom_select)
			hit = blk == '0 && {3'h0, sec} < size;
		else
			hit = blk == '1 && {3'h0, sec} >= 7'h10 - size;
		return hit ^ protect_complement;
	endfunction

	// Registered verdict one cycle after each request
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			check_done <= 1'b0;
			check_refused <= 1'b0;
		end else begin
			check_done <= check_valid;
			if (per_block_protect_select)
				check_refused <= check_valid && (reset_busy ||
					locks[check_addr[LOCK_IDX_LSB +: LOCK_IDX_W]]);
			else
				check_refused <= check_valid &&
					(reset_busy || range_hit(check_addr));
		end
	end

endmodule

// file: src/lock_reset_host.sv
`timescale 1ns/10ps
module lock_reset_host (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Serial link
	spi_lock_if.host link
);
	import spi_lock_pkg::*;

	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	logic [3:0] wr_addr;
	logic [31:0] wr_data;
	logic [ADDR_BITS-1:0] addr_reg;
	logic [7:0] rx_byte;
	logic busy;
	logic launch;

	// Address and data taken in either order, answered when both in
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			wr_addr <= 4'h0;
			wr_data <= 32'h0;
		end else begin
			if (awvalid && awready) begin
				wr_addr <= awaddr;
				awready <= 1'b0;
			end
			if (wvalid && wready) begin
				wr_data <= wdata;
				wready <= 1'b0;
			end
			if (!awready && !wready && !bvalid) begin
				bvalid <= 1'b1;
				if ((wr_addr == REG_CMD || wr_addr == REG_ADDR) && !busy)
					bresp <= RESP_OKAY;
				else
					bresp <= RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// A command write while idle starts a frame; busy writes refused
	assign launch = !awready && !wready && !bvalid && !busy &&
		wr_addr == REG_CMD;

	// Address register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			addr_reg <= '0;
		else if (!awready && !wready && !bvalid && !busy &&
			wr_addr == REG_ADDR)
			addr_reg <= wr_data[ADDR_BITS-1:0];
	end

	// Reads answer one cycle after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			case (araddr)
				REG_ADDR: rdata <= {8'h00, addr_reg};
				REG_STATUS: rdata <= {16'h0000, rx_byte, 7'h00, busy};
				default: begin
					rdata <= 32'h0;
					rresp <= RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	host_state_t state;
	logic [QUERY_BITS-1:0] tx;
	logic [5:0] bit_idx;
	logic [5:0] bit_total;
	logic [5:0] tx_bits;
	logic [3:0] div;
	logic [CNT_W-1:0] gap_cnt;
	logic [7:0] sent_op;
	logic tick;
	logic miso_meta;
	logic miso_s;

	// Returning data crosses in through two flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			miso_meta <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			miso_meta <= link.miso;
			miso_s <= miso_meta;
		end
	end

	// Half-period enable for the link clock
	assign tick = div == 4'(SCK_HALF_CYCLES - 1);
	always_ff @(posedge aclk) begin
		if (!aresetn || launch || tick)
			div <= 4'h0;
		else
			div <= div + 4'h1;
	end

	// Frame sequencer; data changes while the clock is low and the
	// answer is sampled at the end of each high phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= H_IDLE;
			busy <= 1'b0;
			link.cs_n <= 1'b1;
			link.sck <= 1'b0;
			link.mosi <= 1'b0;
			tx <= '0;
			bit_idx <= 6'h00;
			bit_total <= 6'h00;
			tx_bits <= 6'h00;
			gap_cnt <= '0;
			sent_op <= 8'h00;
			rx_byte <= 8'h00;
		end else begin
			case (state)
				H_IDLE: if (launch) begin
					tx <= {wr_data[7:0], addr_reg};
					sent_op <= wr_data[7:0];
					tx_bits <= wr_data[CMD_ADDR_BIT] ?
						6'(QUERY_BITS) : 6'(OPCODE_BITS);
					bit_total <= (wr_data[CMD_ADDR_BIT] ?
						6'(QUERY_BITS) : 6'(OPCODE_BITS)) +
						(wr_data[CMD_READ_BIT] ? 6'(READ_BITS) : 6'h00);
					bit_idx <= 6'h00;
					link.cs_n <= 1'b0;
					link.mosi <= wr_data[7];
					busy <= 1'b1;
					state <= H_SHIFT;
				end
				H_SHIFT: if (tick) begin
					link.sck <= !link.sck;
					if (link.sck) begin
						if (bit_idx >= tx_bits)
							rx_byte <= {rx_byte[6:0], miso_s};
						tx <= {tx[QUERY_BITS-2:0], 1'b0};
						link.mosi <= tx[QUERY_BITS-2];
						bit_idx <= bit_idx + 6'h01;
						if (bit_idx + 6'h01 == bit_total)
							state <= H_GAP;
					end
				end
				H_GAP: if (!link.cs_n) begin
					if (tick) begin
						link.cs_n <= 1'b1;
						link.mosi <= 1'b0;
						// After a reset the device is deaf for its interval
						gap_cnt <= (sent_op == OP_RESET_DEVICE) ?
							CNT_W'(RESET_CYCLES + GAP_CYCLES) :
							CNT_W'(GAP_CYCLES);
					end
				end else if (gap_cnt != '0)
					gap_cnt <= gap_cnt - 1'b1;
				else begin
					busy <= 1'b0;
					state <= H_IDLE;
				end
				default: state <= H_IDLE;
			endcase
		end
	end

endmodule

// file: verification/lock_link_asserts.sv
`timescale 1ns/10ps
module lock_link_asserts (
	// System
	input wire logic aclk,
	input wire logic aresetn,
	// Serial link
	input wire logic cs_n,
	input wire logic sck,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ---------------------------------------------------------------
	// Helper counters
	// ---------------------------------------------------------------
	logic sck_d;
	logic [9:0] gap_cnt;
	logic [5:0] rise_cnt;
	logic [3:0] fall_age;

	// Previous link clock level, for edge finding
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sck_d <= 1'b0;
		else
			sck_d <= sck;
	end

	// Idle span, saturating so a long pause never wraps to zero
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gap_cnt <= 10'h3FF;
		else if (!cs_n)
			gap_cnt <= 10'h000;
		else if (gap_cnt != 10'h3FF)
			gap_cnt <= gap_cnt + 10'h001;
	end

	// Rising link clock edges within the current frame
	always_ff @(posedge aclk) begin
		if (!aresetn || cs_n)
			rise_cnt <= 6'h00;
		else if (sck && !sck_d && rise_cnt != 6'h3F)
			rise_cnt <= rise_cnt + 6'h01;
	end

	// Cycles since the last falling link clock edge
	always_ff @(posedge aclk) begin
		if (!aresetn || (!sck && sck_d))
			fall_age <= 4'h0;
		else if (fall_age != 4'hF)
			fall_age <= fall_age + 4'h1;
	end

	// ---------------------------------------------------------------
	// Link rules
	// ---------------------------------------------------------------
	sck_idle_a: assert property (cs_n |-> !sck)
		else $error("link clock high outside a frame");
	sck_high_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
		else $error("link clock high phase not eight cycles");
	sck_low_a: assert property ($fell(sck) |-> !sck [*8])
		else $error("link clock low phase shorter than eight cycles");
	mosi_hold_a: assert property (sck && !$rose(sck) |-> $stable(mosi))
		else $error("serial input moved while clock high");
	cs_gap_a: assert property ($fell(cs_n) |-> gap_cnt >= 10'd16)
		else $error("select high for fewer than sixteen cycles");
	cs_edge_a: assert property ($changed(cs_n) |-> !sck)
		else $error("select moved while link clock high");
	oe_late_a: assert property ($rose(miso_oe) |->
		!cs_n && rise_cnt == 6'd32)
		else $error("output enabled before opcode and address ended");
	miso_fall_a: assert property (miso_oe && $past(miso_oe) &&
		$changed(miso) |-> fall_age <= 4'd7)
		else $error("serial output moved away from a falling edge");
	oe_release_a: assert property ($rose(cs_n) |-> ##[1:6] !miso_oe)
		else $error("output still enabled after deselect");

	lock_read_c: cover property ($rose(miso_oe));
endmodule

// file: verification/tb.sv
`timescale 1ns/10ps
module tb;
	import spi_lock_pkg::*;

	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic per_block_protect_select = 1'b1, protect_complement = 1'b0;
	logic suspend_set = 1'b0, wrap_load = 1'b0, check_valid = 1'b0;
	logic [2:0] wrap_value = 3'h0, wrap_setting_bits;
	logic [2:0] protect_range_bits = 3'h0;
	logic [ADDR_BITS-1:0] check_addr = 24'h000000;
	logic check_done, check_refused, write_enable_latch_bit;
	logic suspend_flag, core_abort, reset_busy;
	int fail_count = 0, tests_run = 0;
	int abort_seen = 0, busy_len = 0, busy_cur = 0;
	logic [LOCK_COUNT-1:0] m_lock;
	logic m_wel, m_arm, m_sus;
	logic [2:0] m_wrap;

	spi_lock_if link();
	lock_reset_device u_lock_reset_device (.aclk(aclk), .aresetn(aresetn),
		.link(link), .per_block_protect_select(per_block_protect_select),
		.protect_complement(protect_complement), .sector_granularity(1'b0),
		.top_bottom_select(1'b0), .protect_range_bits(protect_range_bits),
		.suspend_set(suspend_set), .wrap_load(wrap_load),
		.wrap_value(wrap_value), .check_valid(check_valid),
		.check_addr(check_addr), .check_done(check_done),
		.check_refused(check_refused), .suspend_flag(suspend_flag),
		.write_enable_latch_bit(write_enable_latch_bit),
		.wrap_setting_bits(wrap_setting_bits), .core_abort(core_abort),
		.reset_busy(reset_busy));
	lock_reset_host u_lock_reset_host (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .link(link));
	lock_link_asserts u_lock_link_asserts (.aclk(aclk), .aresetn(aresetn),
		.cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
		.miso(link.miso), .miso_oe(link.miso_oe));

	// Free-running system clock
	always #20 aclk = ~aclk;

	// Soft reset pulses and busy span, measured beside the traffic
	always @(posedge aclk) begin
		if (core_abort === 1'b1)
			abort_seen <= abort_seen + 1;
		if (reset_busy === 1'b1)
			busy_cur <= busy_cur + 1;
		else if (busy_cur != 0) begin
			busy_len <= busy_cur;
			busy_cur <= 0;
		end
	end

	// ---------------------------------------------------------------
	// Compare, bus and link tasks
	// ---------------------------------------------------------------
	task automatic cmp_v(input string what, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic cmp_bit(input string what, input logic e, input logic g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %b seen %b", what, e, g);
		end
	endtask

	// Bready rides with the request; the slave answers only after both takes
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// No cycle count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
				awvalid <= 1'b0;
			if (wvalid && wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arvalid && arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// Launch one frame and step the reference model
	task automatic spi_send(input logic [7:0] op, input logic [1:0] fl,
		input logic [23:0] ad);
		logic [1:0] r;
		axi_wr(REG_ADDR, {8'h00, ad}, r);
		axi_wr(REG_CMD, {22'h0, fl, op}, r);
		cmp_v("command resp", 32'(RESP_OKAY), 32'(r));
		case (op)
			OP_WRITE_ENABLE: m_wel = 1'b1;
			OP_WRITE_DISABLE: m_wel = 1'b0;
			OP_GLOBAL_LOCK, OP_GLOBAL_UNLOCK: if (m_wel) begin
				m_lock = {LOCK_COUNT{op == OP_GLOBAL_LOCK}};
				m_wel = 1'b0;
			end
			OP_RESET_DEVICE: if (m_arm) begin
				m_lock = LOCKS_AT_RESET;
				{m_wel, m_sus, m_wrap} = 5'h00;
			end
			default: ;
		endcase
		m_arm = (op == OP_RESET_ENABLE);
	endtask

	task automatic spi_wait(output logic [31:0] st);
		logic [1:0] r;
		do
			axi_rd(REG_STATUS, st, r);
		while (st[STATUS_BUSY_BIT] !== 1'b0);
	endtask

	task automatic spi_op(input logic [7:0] op, input logic [1:0] fl,
		input logic [23:0] ad, output logic [31:0] st);
		spi_send(op, fl, ad);
		spi_wait(st);
		cmp_bit("latch", m_wel, write_enable_latch_bit);
	endtask

	// Both ends of the lock array plus one random place
	task automatic query_set();
		logic [31:0] st;
		logic [23:0] ad [3];
		ad = '{24'h000000, 24'h3FFFFF, 24'($urandom())};
		foreach (ad[i]) begin
			spi_op(OP_READ_LOCK, 2'b11, ad[i], st);
			cmp_v("lock byte", 32'(m_lock[ad[i][21:16]]),
				32'(st[STATUS_DATA_LSB +: 8]));
		end
	endtask

	task automatic chk(input logic exp);
		@(posedge aclk);
		check_valid <= 1'b1;
		check_addr <= 24'($urandom());
		@(posedge aclk);
		check_valid <= 1'b0;
		for (int n = 0; n < 3; n++) begin
			#1;
			if (check_done === 1'b1)
				break;
			@(posedge aclk);
		end
		cmp_bit("check done", 1'b1, check_done);
		cmp_bit("refused", exp, check_refused);
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog, well beyond the roughly 16k cycles the tests need
	initial begin
		#(80000 * 40);
		fail_count++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		logic [31:0] st;
		logic [1:0] r;
		logic [23:0] ad;
		void'($urandom(50860));
		m_lock = LOCKS_AT_RESET;
		{m_wel, m_arm, m_sus, m_wrap} = 6'h00;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		query_set();
		ad = 24'($urandom());
		axi_wr(REG_ADDR, {8'h00, ad}, r);
		axi_rd(REG_ADDR, st, r);
		cmp_v("address reg", 32'(ad), 32'(st[23:0]));
		axi_rd(4'hC, st, r);
		cmp_v("unmapped resp", 32'(RESP_SLVERR), 32'(r));
		axi_rd(REG_CMD, st, r);
		cmp_v("command read resp", 32'(RESP_SLVERR), 32'(r));
		axi_wr(REG_STATUS, 32'h0, r);
		cmp_v("status write resp", 32'(RESP_SLVERR), 32'(r));
		chk(1'b1);
		$display("test power-on state done");
		spi_op(OP_GLOBAL_UNLOCK, 2'b00, 24'h0, st);
		query_set();
		$display("test unlock without latch done");
		spi_op(OP_WRITE_ENABLE, 2'b00, 24'h0, st);
		spi_op(OP_GLOBAL_UNLOCK, 2'b00, 24'h0, st);
		query_set();
		chk(1'b0);
		per_block_protect_select <= 1'b0;
		protect_complement <= 1'b1;
		chk(1'b1);
		protect_complement <= 1'b0;
		chk(1'b0);
		$display("test global unlock done");
		spi_op(OP_WRITE_ENABLE, 2'b00, 24'h0, st);
		spi_op(OP_GLOBAL_LOCK, 2'b00, 24'h0, st);
		query_set();
		chk(1'b0);
		protect_range_bits <= 3'h7;
		chk(1'b1);
		protect_range_bits <= 3'h0;
		per_block_protect_select <= 1'b1;
		chk(1'b1);
		$display("test global lock done");
		spi_op(OP_WRITE_ENABLE, 2'b00, 24'h0, st);
		spi_op(OP_GLOBAL_UNLOCK, 2'b00, 24'h0, st);
		@(posedge aclk);
		m_wrap = 3'($urandom());
		suspend_set <= 1'b1;
		wrap_load <= 1'b1;
		wrap_value <= m_wrap;
		@(posedge aclk);
		suspend_set <= 1'b0;
		wrap_load <= 1'b0;
		m_sus = 1'b1;
		spi_op(OP_RESET_ENABLE, 2'b00, 24'h0, st);
		spi_op(OP_WRITE_ENABLE, 2'b00, 24'h0, st);
		spi_op(OP_RESET_DEVICE, 2'b00, 24'h0, st);
		query_set();
		cmp_bit("suspend", m_sus, suspend_flag);
		cmp_v("abort count", 32'd0, 32'(abort_seen));
		$display("test broken reset pair done");
		spi_op(OP_RESET_ENABLE, 2'b00, 24'h0, st);
		// The reset sets every lock again, but the range passes, so only the interval refuses
		per_block_protect_select <= 1'b0;
		fork
			spi_op(OP_RESET_DEVICE, 2'b00, 24'h0, st);
			begin
				for (int i = 0; i < 400 && reset_busy !== 1'b1; i++)
					@(posedge aclk);
				chk(1'b1);
			end
		join
		cmp_v("abort count", 32'd1, 32'(abort_seen));
		cmp_bit("reset span", 1'b1, 1'(busy_len >= RESET_CYCLES &&
			busy_len <= RESET_CYCLES + 4));
		cmp_bit("suspend", m_sus, suspend_flag);
		cmp_v("wrap", 32'(m_wrap), 32'(wrap_setting_bits));
		query_set();
		$display("test soft reset done");
		spi_op(OP_WRITE_ENABLE, 2'b00, 24'h0, st);
		spi_send(OP_WRITE_DISABLE, 2'b00, 24'h0);
		axi_wr(REG_CMD, {24'h0, OP_WRITE_ENABLE}, r);
		cmp_v("busy write resp", 32'(RESP_SLVERR), 32'(r));
		spi_wait(st);
		cmp_bit("latch", m_wel, write_enable_latch_bit);
		$display("test write while busy done");
		stop_test();
	end
endmodule
